// file: rtl/plm_pkg.sv
// Package for the link power manager: constants, state codes, carriers.
// Assumes a 125 MHz core clock and a 32-bit AHB-Lite register port.
package plm_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int          CLK_NS   = 8;        // Clock period in ns
   localparam int          IDLE_NS  = 6000;     // Idle time before standby
   localparam int          SMP_NS   = 100000;   // Wake pin sample period
   localparam int          IDLE_CYC = (IDLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int          SMP_CYC  = SMP_NS / CLK_NS;
   localparam logic [11:0] IDLE_CNT = 12'(IDLE_CYC);

   // ----------------------------------------------------------------
   // Register map (byte addresses) and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL  = 8'h00;    // Link / command control
   localparam logic [7:0] OFF_PMCSR = 8'h04;    // Power state control
   localparam logic [7:0] OFF_LCAP  = 8'h08;    // Link capabilities
   localparam logic [7:0] OFF_STAT  = 8'h0c;    // Live status
   localparam logic [7:0] OFF_NONE  = 8'hff;    // Marks an unmapped write
   localparam int         CTRL_ASPM = 0;        // [1:0] entry control
   localparam int         CTRL_CMD  = 2;        // [4:2] mem, io, master
   localparam int         PMCSR_NSR = 3;        // No-soft-reset flag
   localparam int         LCAP_ASPM = 10;       // [11:10] standby support
   localparam int         STAT_DEV  = 8;        // [10:8] device state
   localparam int         STAT_PME  = 16;       // Wake event pending
   localparam logic [1:0] LCAP_L0S  = 2'h1;     // Standby only supported
   localparam logic [1:0] PS_D0     = 2'h0;     // Power state code D0
   localparam logic [1:0] PS_D3H    = 2'h3;     // Power state code D3hot

   // ----------------------------------------------------------------
   // State codes
   // ----------------------------------------------------------------
   typedef enum logic [6:0] {
      LNK_DOWN   = 7'h01,                       // Link down pseudo state
      LNK_L0     = 7'h02,
      LNK_L0S    = 7'h04,
      LNK_L1ENT  = 7'h08,
      LNK_L1     = 7'h10,
      LNK_L1EXIT = 7'h20,
      LNK_L23    = 7'h40
   } plm_lnk_t;

   typedef enum logic [2:0] {
      DEV_D0U = 3'h1,                           // D0 uninitialized
      DEV_D0A = 3'h2,                           // D0 active
      DEV_D3H = 3'h4                            // D3hot
   } plm_dev_t;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic link_up;                            // Physical layer in L0
      logic tx_pending;                         // TLP or DLLP waiting
      logic tx_sent;                            // Packet sent this cycle
      logic rx_activity;                        // Traffic from serial side
      logic pbus_activity;                      // Traffic from parallel side
      logic l1_ack;                             // Upstream accepted L1
      logic up_exit;                            // Upstream starts L1 exit
      logic turn_off;                           // Turn-off message seen
   } plm_lnk_in_t;

   typedef struct packed {
      logic     tx_allow;                       // Transmit permitted
      logic     l1_req;                         // Request L1 entry
      logic     wake;                           // Drive link back to L0
      logic     turn_off_ack;                   // Answer turn-off, pulse
      logic     pme_msg;                        // Send wake message, pulse
      plm_lnk_t state;                          // Link power state
      plm_dev_t dev;                            // Device power state
   } plm_lnk_out_t;

   typedef struct packed {
      plm_lnk_t     lnk;
      plm_dev_t     dev;
      logic [1:0]   aspm;
      logic [2:0]   cmd;
      logic [11:0]  idle;
      logic [15:0]  smp;
      logic         pme_pend;
      logic         turn_pend;
      plm_lnk_out_t out;
      logic         wr_pend;
      logic [7:0]   wr_addr;
      logic [31:0]  hrdata;
      logic         hready;
      logic         hresp;
   } plm_state_t;

   localparam plm_state_t STATE_RST = '{lnk: LNK_DOWN, dev: DEV_D0U,
      out: '{state: LNK_DOWN, dev: DEV_D0U, default: 1'b0},
      hready: 1'b1, default: '0};

endpackage

// file: rtl/plm_link_pm.sv
// Link power manager for the upstream serial link of a bus bridge.
// Assumes the physical layer handles electrical idle and retraining,
// and that a single AHB-Lite master reaches the registers.
//
// Functional notes
// R1: Standby entry disabled until software enables it
// R2: Enter standby after 6 us transmit idle
// R3: Pending TLP or DLLP starts standby exit
// R4: No transmission while transmitter in standby
// R5: Each direction's standby state is independent
// R6: Idle timing never moves link into L1
// R7: Writing D3hot starts L1 entry
// R8: No traffic in L1 until back in L0
// R9: Either side may start L1 exit
// R10: Answer turn-off message, enter L2/L3 Ready
// R11: No traffic once in L2/L3 Ready
// R12: Accept turn-off handshake even from D0
// R13: Start D0 uninit; enables move to active
// R14: Configuration access works in D3hot
// R15: Report no-soft-reset as one
// R16: Only D0, D3hot and D3cold exist
// R17: No wake events without power
// R18: Activity on either side ends standby
// R19: Advertise standby capability in capabilities register
// R20: Link down pseudo state before first L0
// R21: Sample wake pin every 100 us
// R22: Bring link to L0 before wake message
// R23: Device follows the power state field
// R24: Idle timer restarts on traffic, clears disabled
// R25: D1 and D2 writes are ignored
`timescale 1ns/1ns

module plm_link_pm
   import plm_pkg::*;
#(
   parameter logic [15:0] SMP_CYC_P = 16'(SMP_CYC)  // Wake sample period
)
(
   input  wire logic         clk_i,
   input  wire logic         resetn_i,
   input  wire logic         hsel_i,
   input  wire logic [31:0]  haddr_i,
   input  wire logic [1:0]   htrans_i,
   input  wire logic         hwrite_i,
   input  wire logic [2:0]   hsize_i,
   input  wire logic [31:0]  hwdata_i,
   input  wire logic         hready_i,
   output logic      [31:0]  hrdata_o,
   output logic              hreadyout_o,
   output logic              hresp_o,
   input  wire plm_lnk_in_t  lnk_i,
   input  wire logic         parallel_bus_wake_request_n_i,
   output plm_lnk_out_t      lnk_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   plm_state_t  s_r;            // All registered state
   plm_state_t  s_nxt;          // Next value of the state
   logic [31:0] rdata;          // Read word for the current address
   logic        act_in;         // Any activity that ends standby

   // Only whole-word transfers are issued, so hsize is not decoded
   assign act_in = lnk_i.tx_pending | lnk_i.rx_activity | lnk_i.pbus_activity;

   // ----------------------------------------------------------------
   // Read multiplexer
   // ----------------------------------------------------------------
   // Selects the register word for the address in the address phase
   always_comb
   begin
      rdata = '0;
      if (haddr_i[31:8] == '0)
      begin
         case (haddr_i[7:0])
            OFF_CTRL:
            begin
               rdata[CTRL_ASPM +: 2] = s_r.aspm;
               rdata[CTRL_CMD +: 3]  = s_r.cmd;
            end
            OFF_PMCSR:
            begin
               // Field always shows the state really held
               rdata[1:0]       = (s_r.dev == DEV_D3H) ? PS_D3H : PS_D0;
               rdata[PMCSR_NSR] = 1'b1;                                 // R15
            end
            OFF_LCAP:
               rdata[LCAP_ASPM +: 2] = LCAP_L0S;                        // R19
            OFF_STAT:
            begin
               rdata[6:0]            = s_r.lnk;
               rdata[STAT_DEV +: 3]  = s_r.dev;
               rdata[STAT_PME]       = s_r.pme_pend;
            end
            default:
               rdata = '0;                // Unmapped reads return zero
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      s_nxt                  = s_r;
      s_nxt.out.turn_off_ack = 1'b0;
      s_nxt.out.pme_msg      = 1'b0;

      // Write data phase: software-visible control; works in D3hot too
      if (s_r.wr_pend)                                                  // R14
      begin
         case (s_r.wr_addr)
            OFF_CTRL:
            begin
               s_nxt.aspm = hwdata_i[CTRL_ASPM +: 2];                   // R1
               s_nxt.cmd  = hwdata_i[CTRL_CMD +: 3];
               // Any space or master enable activates the function
               if (s_r.dev == DEV_D0U && |hwdata_i[CTRL_CMD +: 3])
                  s_nxt.dev = DEV_D0A;                                  // R13
            end
            OFF_PMCSR:
            begin
               // Follow the field; D1 and D2 codes change nothing
               if (hwdata_i[1:0] == PS_D3H)
                  s_nxt.dev = DEV_D3H;                                  // R23
               else if (hwdata_i[1:0] == PS_D0 && s_r.dev == DEV_D3H)
                  s_nxt.dev = DEV_D0U;                                  // R14
               else
                  s_nxt.dev = s_r.dev;                                  // R25 R16
            end
            default:
               s_nxt.dev = s_r.dev;     // Unmapped writes are dropped
         endcase
      end

      // Address phase: zero wait states, response always OKAY
      s_nxt.wr_pend = 1'b0;
      if (hsel_i && hready_i && htrans_i[1])
      begin
         if (hwrite_i)
         begin
            s_nxt.wr_pend = 1'b1;
            s_nxt.wr_addr = (haddr_i[31:8] == '0) ? haddr_i[7:0] : OFF_NONE;
         end
         else
            s_nxt.hrdata = rdata;
      end

      // Idle timer: counts quiet L0 cycles, saturates at the limit
      if (s_r.lnk == LNK_L0 && s_r.aspm[0] && !(lnk_i.tx_sent || lnk_i.tx_pending))
      begin
         if (s_r.idle != IDLE_CNT)
            s_nxt.idle = s_r.idle + 12'h1;
      end
      else
         s_nxt.idle = '0;                                               // R24

      // A turn-off seen in L0s, L1 or L1 exit waits until the link is back
      if (lnk_i.turn_off && (s_r.lnk == LNK_L0S || s_r.lnk == LNK_L1 ||
                             s_r.lnk == LNK_L1EXIT))
         s_nxt.turn_pend = 1'b1;

      // Link power state machine
      unique case (s_r.lnk)
         LNK_DOWN:
            if (lnk_i.link_up)
               s_nxt.lnk = LNK_L0;                                      // R20
         LNK_L0:
            if (!lnk_i.link_up)
               s_nxt.lnk = LNK_DOWN;
            else if (lnk_i.turn_off || s_r.turn_pend)
            begin
               // Handshake taken in any device state
               s_nxt.lnk              = LNK_L23;                        // R10 R12
               s_nxt.out.turn_off_ack = 1'b1;
               s_nxt.turn_pend        = 1'b0;
            end
            else if (s_r.pme_pend)
            begin
               s_nxt.out.pme_msg = 1'b1;                                // R22
               s_nxt.pme_pend    = 1'b0;
            end
            else if (s_r.dev == DEV_D3H)
               s_nxt.lnk = LNK_L1ENT;                                   // R7
            else if (s_r.aspm[0] && s_r.idle == IDLE_CNT)
               s_nxt.lnk = LNK_L0S;                                     // R2 R6
         LNK_L0S:
            // Only the transmit side sleeps; receive runs on
            if (act_in || s_r.pme_pend || s_r.turn_pend ||
                lnk_i.turn_off || s_r.dev == DEV_D3H)
               s_nxt.lnk = LNK_L0;                                      // R3 R18 R5
            else if (!lnk_i.link_up)
               s_nxt.lnk = LNK_DOWN;
         LNK_L1ENT:
            if (lnk_i.turn_off)
            begin
               s_nxt.lnk              = LNK_L23;                        // R10
               s_nxt.out.turn_off_ack = 1'b1;
            end
            else if (s_r.dev != DEV_D3H)
               s_nxt.lnk = LNK_L0;
            else if (lnk_i.l1_ack)
               s_nxt.lnk = LNK_L1;
         LNK_L1:
            // Exit started by upstream or by this end
            if (lnk_i.up_exit || s_r.pme_pend || s_r.turn_pend ||
                s_r.dev != DEV_D3H || lnk_i.tx_pending)
               s_nxt.lnk = LNK_L1EXIT;                                  // R9
         LNK_L1EXIT:
            if (lnk_i.link_up)
               s_nxt.lnk = LNK_L0;                                      // R9
         LNK_L23:
            s_nxt.lnk = LNK_L23;        // Left only by power removal
      endcase

      // Wake pin sampling; the set wins over the clear above
      if (s_r.smp >= SMP_CYC_P - 16'h1)
      begin
         s_nxt.smp = '0;
         if (!parallel_bus_wake_request_n_i && s_r.lnk != LNK_L23)
            s_nxt.pme_pend = 1'b1;                                      // R21 R17
      end
      else
         s_nxt.smp = s_r.smp + 16'h1;

      // Registered link outputs follow the next state
      s_nxt.out.tx_allow = (s_nxt.lnk == LNK_L0);                       // R4 R8 R11
      s_nxt.out.l1_req   = (s_nxt.lnk == LNK_L1ENT);
      s_nxt.out.wake     = (s_nxt.lnk == LNK_L1EXIT);
      s_nxt.out.state    = s_nxt.lnk;
      s_nxt.out.dev      = s_nxt.dev;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         s_r <= STATE_RST;                                              // R1 R13
      else
         s_r <= s_nxt;
   end

   // Outputs straight from flip-flops
   assign hrdata_o    = s_r.hrdata;
   assign hreadyout_o = s_r.hready;
   assign hresp_o     = s_r.hresp;
   assign lnk_o       = s_r.out;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   AST_TX_BLOCK: assert property (lnk_o.tx_allow |-> s_r.lnk == LNK_L0) // R4
      else $error("transmit allowed outside L0");

   AST_ASPM_OFF: assert property (!s_r.aspm[0] |=> s_r.lnk != LNK_L0S
                                  || $past(s_r.lnk) == LNK_L0S)      // R1
      else $error("standby entered while disabled");

   AST_IDLE_TIME: assert property ($rose(s_r.lnk == LNK_L0S)
                                   |-> $past(s_r.idle) == IDLE_CNT)  // R2
      else $error("standby entered before idle time");

   AST_L0S_EXIT: assert property ((s_r.lnk == LNK_L0S && act_in)
                                  |=> s_r.lnk == LNK_L0)             // R3
      else $error("standby not left on activity");

   AST_L1_SW_ONLY: assert property ($rose(s_r.lnk == LNK_L1)
                                    |-> $past(s_r.lnk) == LNK_L1ENT
                                        && $past(s_r.dev) == DEV_D3H) // R6
      else $error("L1 reached without D3hot");

   AST_D3_L1: assert property ((s_r.dev == DEV_D3H && s_r.lnk == LNK_L0
                                && lnk_i.link_up && !lnk_i.turn_off
                                && !s_r.turn_pend && !s_r.pme_pend)
                               |=> s_r.lnk == LNK_L1ENT ##0 lnk_o.l1_req) // R7
      else $error("D3hot did not start L1 entry");

   AST_TURN_OFF: assert property ((lnk_i.turn_off && s_r.lnk == LNK_L0
                                   && lnk_i.link_up)
                                  |=> s_r.lnk == LNK_L23
                                      && lnk_o.turn_off_ack)         // R10
      else $error("turn-off not answered");

   AST_L23_HOLD: assert property (s_r.lnk == LNK_L23
                                  |=> (s_r.lnk == LNK_L23
                                       && !lnk_o.tx_allow)[*2])      // R11
      else $error("traffic or exit after L2/L3 Ready");

   AST_DEV_LEGAL: assert property (s_r.dev inside {DEV_D0U, DEV_D0A,
                                                   DEV_D3H})         // R16
      else $error("illegal device state");

   AST_PME_IN_L0: assert property (lnk_o.pme_msg
                                   |-> $past(s_r.lnk) == LNK_L0)     // R22
      else $error("wake message outside L0");

   COV_L0S: cover property (s_r.lnk == LNK_L0S ##1 s_r.lnk == LNK_L0);
   COV_L1_EXIT: cover property (s_r.lnk == LNK_L1 ##1 s_r.lnk == LNK_L1EXIT);
   COV_L23_D0: cover property (s_r.dev != DEV_D3H && lnk_o.turn_off_ack);
   COV_PME: cover property (lnk_o.pme_msg);

endmodule

// file: verif/plm_up_model.sv
// Upstream port model facing the link power manager.
// Assumes one shared clock and the device outputs of plm_link_pm.
`timescale 1ns/1ns

module plm_up_model
   import plm_pkg::*;
(
   input  wire logic         clk_i,
   input  wire logic         resetn_i,
   input  wire plm_lnk_out_t dev_i,
   input  wire logic         slow_i,
   input  wire logic         turn_off_cmd_i,
   input  wire logic         exit_cmd_i,
   input  wire logic         rx_cmd_i,
   output plm_lnk_in_t       up_o
);
   // ----------------------------------------------------------------
   // Handshake timing
   // ----------------------------------------------------------------
   logic [5:0] cnt_r;   // Cycles spent in a waiting state
   logic [5:0] dly;     // Answer delay, prompt or slow
   logic       up_r;    // Link trained
   logic       ack_r;   // L1 accepted
   logic       ex_r;    // Exit from L1 begun here
   logic       to_r;    // Turn-off message
   logic       rx_r;    // Receive traffic
   logic       may_tx;  // Link open for our traffic
   logic       hold;    // Waiting for our answer
   plm_lnk_t   st;

   assign st     = dev_i.state;
   assign dly    = slow_i ? 6'h28 : 6'h03;
   assign may_tx = (st == LNK_L0) || (st == LNK_L0S);
   assign hold   = (st == LNK_DOWN) || (st == LNK_L1ENT) || (st == LNK_L1EXIT);

   // Training, L1 answer and gated traffic
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         cnt_r <= 6'h00;
         up_r  <= 1'b0;
         ack_r <= 1'b0;
         ex_r  <= 1'b0;
         to_r  <= 1'b0;
         rx_r  <= 1'b0;
      end
      else
      begin
         cnt_r <= hold ? cnt_r + 6'h01 : 6'h00;
         // Link drops in L1 and retrains on exit
         if (st == LNK_L1)
            up_r <= 1'b0;
         else if (hold && cnt_r == dly)
            up_r <= 1'b1;
         ack_r <= (st == LNK_L1ENT) && (cnt_r == dly);
         ex_r  <= exit_cmd_i && (st == LNK_L1);
         to_r  <= turn_off_cmd_i && may_tx;
         rx_r  <= rx_cmd_i && may_tx;
      end
   end

   assign up_o = '{link_up: up_r, l1_ack: ack_r, up_exit: ex_r, turn_off: to_r,
                   rx_activity: rx_r, default: 1'b0};
endmodule

// file: verif/plm_link_pm_tb.sv
// Self-checking bench for the link power manager.
// Assumes plm_up_model on the link and a single AHB-Lite master here.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("BAD %s exp %0h got %0h", nm, e, g); end end

module plm_link_pm_tb;
   import plm_pkg::*;
   localparam int SMP = 16;  // Short wake sample period
   logic         clk_i = 0, resetn_i = 0, hsel = 0, hwrite = 0;
   logic         tx_pend = 0, tx_sent = 0, pbus = 0, wake_n = 1;
   logic         to_cmd = 0, ex_cmd = 0, rx_cmd = 0, slow = 0;
   logic [1:0]   htrans = 0, ps;
   logic [31:0]  haddr = 0, hwdata = 0, hrdata, rd;
   logic         hreadyout, hresp;
   plm_lnk_in_t  lnk_in, up_w;
   plm_lnk_out_t lnk_o;
   plm_dev_t     dv, pv;
   plm_lnk_t     pme_st;
   int           error_cnt = 0, n_tests = 0, seed = 31, k, i, pme_cnt = 0, ack_cnt = 0;

   initial forever #4 clk_i = ~clk_i;
   assign lnk_in = up_w | plm_lnk_in_t'({1'b0, tx_pend, tx_sent, 1'b0, pbus, 3'b0});

   plm_link_pm #(.SMP_CYC_P(16'(SMP))) plm_link_pm_inst (.clk_i(clk_i), .resetn_i(resetn_i),
      .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
      .hresp_o(hresp), .lnk_i(lnk_in), .parallel_bus_wake_request_n_i(wake_n), .lnk_o(lnk_o));
   plm_up_model plm_up_model_inst (.clk_i(clk_i), .resetn_i(resetn_i), .dev_i(lnk_o),
      .slow_i(slow), .turn_off_cmd_i(to_cmd), .exit_cmd_i(ex_cmd), .rx_cmd_i(rx_cmd),
      .up_o(up_w));

   // Pulse counters on the link side
   always @(posedge clk_i)
   begin
      if (lnk_o.pme_msg === 1'b1)
      begin
         pme_cnt++;
         pme_st = lnk_o.state;
      end
      if (lnk_o.turn_off_ack === 1'b1)
         ack_cnt++;
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      n = 0;
      do begin @(posedge clk_i); n++; end while (hreadyout !== 1'b1 && n < 50);
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(posedge clk_i); n++; end while (hreadyout !== 1'b1 && n < 100);
      rd = hrdata;
      `CHK("hresp", 1'b0, hresp)
      if (n >= 50)
      begin
         error_cnt++;
         $display("BAD hready exp 1 got stall");
      end
   endtask

   task automatic wst(input plm_lnk_t s, input int lim);
      k = 0;
      while (lnk_o.state !== s && k < lim) begin @(posedge clk_i); k++; end
      `CHK("state", s, lnk_o.state)
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // Device state expected after a power state write
   function automatic plm_dev_t exp_dev(plm_dev_t c, logic [1:0] p);
      if (p == PS_D3H)
         return DEV_D3H;
      if (p == PS_D0 && c == DEV_D3H)
         return DEV_D0U;
      return c;
   endfunction

   task automatic results();
      $display("errors %0d checks %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin #600000; error_cnt++; results(); end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      cyc(10);
      `CHK("st_rst", LNK_DOWN, lnk_o.state)
      `CHK("dev_rst", DEV_D0U, lnk_o.dev)
      resetn_i <= 1'b1;
      wst(LNK_L0, 40);
      ahb(0, OFF_LCAP, 0);
      `CHK("lcap", LCAP_L0S, rd[LCAP_ASPM+:2])
      ahb(0, OFF_PMCSR, 0);
      `CHK("nsr", 1'b1, rd[PMCSR_NSR])
      ahb(0, 8'h20, 0);
      `CHK("unmapped", 32'h0, rd)
      cyc(800);
      `CHK("no_entry", LNK_L0, lnk_o.state)
      ahb(1, OFF_CTRL, 32'h1 | (32'(3'($random(seed)) | 3'h1) << CTRL_CMD));
      wst(LNK_L0S, 1000);
      `CHK("idle", 1'b1, (k >= IDLE_CYC - 2 && k <= IDLE_CYC + 3))
      `CHK("tx_off", 1'b0, lnk_o.tx_allow)
      // Each activity exit cause, then a restarted idle timer
      for (i = 0; i < 3; i++)
      begin
         tx_pend <= (i == 0);
         pbus    <= (i == 1);
         rx_cmd  <= (i == 2);
         wst(LNK_L0, 6);
         `CHK("tx_on", 1'b1, lnk_o.tx_allow)
         tx_pend <= 1'b0;
         pbus    <= 1'b0;
         rx_cmd  <= 1'b0;
         cyc(300);
         tx_sent <= 1'b1;
         cyc(1);
         tx_sent <= 1'b0;
         wst(LNK_L0S, 1000);
         `CHK("restart", 1'b1, (k >= IDLE_CYC - 2 && k <= IDLE_CYC + 3))
      end
      ahb(0, OFF_STAT, 0);
      `CHK("d0a", DEV_D0A, rd[STAT_DEV+:3])
      // Power state writes, legal and ignored
      dv = DEV_D0A;
      slow <= 1'b1;
      for (i = 0; i < 10; i++)
      begin
         ps = (i < 4) ? 2'(i) : 2'($random(seed));
         pv = dv;
         dv = exp_dev(dv, ps);
         ahb(1, OFF_PMCSR, 32'(ps));
         ahb(0, OFF_STAT, 0);
         `CHK("dev", dv, rd[STAT_DEV+:3])
         if (dv == DEV_D3H && pv != DEV_D3H)
         begin
            wst(LNK_L1ENT, 100);
            `CHK("l1_req", 1'b1, lnk_o.l1_req)
            wst(LNK_L1, 100);
            `CHK("l1_tx", 1'b0, lnk_o.tx_allow)
         end
      end
      slow <= 1'b0;
      ahb(1, OFF_PMCSR, 32'(PS_D3H));
      wst(LNK_L1, 200);
      ex_cmd <= 1'b1;
      cyc(1);
      ex_cmd <= 1'b0;
      wst(LNK_L1EXIT, 6);
      `CHK("wake", 1'b1, lnk_o.wake)
      wst(LNK_L0, 100);
      wst(LNK_L1, 200);
      // Wake pin sampling from L1
      cyc(3 * SMP);
      `CHK("pme_idle", 0, pme_cnt)
      wake_n <= 1'b0;
      k = 0;
      while (pme_cnt == 0 && k < 2 * SMP + 80) begin @(posedge clk_i); k++; end
      wake_n <= 1'b1;
      `CHK("pme", 1'b1, (pme_cnt > 0))
      `CHK("pme_l0", LNK_L0, pme_st)
      // Turn-off from D0
      ahb(1, OFF_PMCSR, 32'(PS_D0));
      wst(LNK_L0, 200);
      to_cmd <= 1'b1;
      cyc(1);
      to_cmd <= 1'b0;
      cyc(10);
      `CHK("ack", 1, ack_cnt)
      `CHK("l23", LNK_L23, lnk_o.state)
      `CHK("l23_tx", 1'b0, lnk_o.tx_allow)
      k = pme_cnt;
      wake_n <= 1'b0;
      cyc(3 * SMP);
      wake_n <= 1'b1;
      `CHK("l23_pme", k, pme_cnt)
      `CHK("l23_hold", LNK_L23, lnk_o.state)
      // Second reset in mid-run
      resetn_i <= 1'b0;
      cyc(3);
      `CHK("st_rst2", LNK_DOWN, lnk_o.state)
      `CHK("dev_rst2", DEV_D0U, lnk_o.dev)
      resetn_i <= 1'b1;
      wst(LNK_L0, 40);
      ahb(0, OFF_CTRL, 0);
      `CHK("ctrl_rst", 32'h0, rd)
      results();
   end
endmodule
